// file: include/reclocker_consts.svh
// offsets, reset values, field positions and codes of the override and boost register slice
`ifndef RECLOCKER_CONSTS_SVH
`define RECLOCKER_CONSTS_SVH
`define OFS_RESERVED_STATUS_A 8'h39
`define OFS_LOW_RATE_BOOST 8'h3a
`define OFS_RESERVED_STATUS_B 8'h3b
`define OFS_RESERVED_STATUS_C 8'h3c
`define OFS_RESERVED_CTRL_D 8'h3d
`define OFS_EYE_LOCK_MONITOR_ENABLE 8'h3e
`define OFS_PIN_OVERRIDE_CONTROL 8'h3f
`define OFS_ADAPT_BOOST_ENTRY_0 8'h40
`define OFS_ADAPT_BOOST_ENTRY_1 8'h41
`define OFS_ADAPT_BOOST_ENTRY_3 8'h43
`define RST_RESERVED_STATUS_A 8'h00
`define RST_LOW_RATE_BOOST 8'h00
`define RST_RESERVED_STATUS_B 8'h96
`define RST_RESERVED_STATUS_C 8'h90
`define RST_RESERVED_CTRL_D 8'h00
`define RST_EYE_LOCK_MONITOR_ENABLE 8'h80
`define RST_PIN_OVERRIDE_CONTROL 8'h01
`define RST_ADAPT_BOOST_ENTRY_0 8'h00
`define RST_ADAPT_BOOST_ENTRY_1 8'h40
`define RST_ADAPT_BOOST_ENTRY_2 8'h80
`define RST_ADAPT_BOOST_ENTRY_3 8'h50
`define BIT_EYE_MONITOR_EN 7
`define BIT_ADAPTATION_OVERRIDE 5
`define BIT_INPUT_ROUTE_OVERRIDE 4
`define BIT_OUTPUT_MUX_OVERRIDE 3
`define BIT_RATE_FAMILY_OVERRIDE 2
`define BIT_BOOST_PIN_OVERRIDE 1
`define BIT_MID_RATE_ADAPT_ENABLE 0
`define ADAPT_MODE_MANUAL 2'h0
`define ADAPT_MODE_AUTO 2'h1
`define ROUTE_SECOND_ONLY 2'h2
`define ROUTE_BOTH 2'h3
`define RATE_FAMILY_VIDEO 2'h0
`define RATE_FAMILY_ETHERNET 2'h1
`endif

// file: include/reclocker_pkg.sv
// types and stage field helper shared by the reclocker override slice
package reclocker_pkg;
  typedef enum logic [1:0] {RATE_SD = 2'b00, RATE_HD = 2'b01, RATE_3G = 2'b10, RATE_HIGH = 2'b11} data_rate_t;
  typedef enum logic [1:0] {
    SRC_FIXED = 2'b00, SRC_TABLE = 2'b01, SRC_MANUAL = 2'b10, SRC_BYPASS = 2'b11
  } boost_src_t;
  typedef enum logic [1:0] {EYE_OFF = 2'b00, EYE_WAIT = 2'b01, EYE_RUN = 2'b10} eye_state_t;

  // stage 0 sits in the top two bits, stage 3 in the bottom two
  function automatic logic [1:0] stage_of(input logic [7:0] boost, input logic [1:0] stage);
    logic [2:0] sh;
    sh = 3'(3'd6 - {stage, 1'b0});
    stage_of = 2'(boost >> sh);
  endfunction
endpackage

// file: include/boost_sel_if.sv
// carrier between the register slice and the boost selector
`timescale 1ns/1ps
interface boost_sel_if;
  import reclocker_pkg::*;
  logic [7:0] low_rate_boost;
  logic [7:0] table_boost;
  logic [7:0] manual_boost_byte;
  logic manual_boost_override;
  logic boost_pin_override;
  logic pin_bypass;
  logic mid_rate_adapt_enable;
  logic adaptation_override;
  logic [1:0] adapt_mode;
  data_rate_t data_rate;
  logic [7:0] boost;
  boost_src_t source;
  logic adapt_on;
  modport regs (output low_rate_boost, table_boost, manual_boost_byte, manual_boost_override,
    boost_pin_override, pin_bypass, mid_rate_adapt_enable, adaptation_override, adapt_mode, data_rate,
    input boost, source, adapt_on);
  modport sel (input low_rate_boost, table_boost, manual_boost_byte, manual_boost_override,
    boost_pin_override, pin_bypass, mid_rate_adapt_enable, adaptation_override, adapt_mode, data_rate,
    output boost, source, adapt_on);
endinterface

// file: core/strap_sync.sv
// three-stage synchroniser for the two strap pins, level taken once stages two and three agree
`timescale 1ns/1ps
module strap_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and filtered levels
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_level
);
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] level_reg;
  wire [1:0] agree = ~(s2_reg ^ s3_reg);
  wire [1:0] level_next = (agree & s2_reg) | (~agree & level_reg);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
      level_reg <= 2'h0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end
  assign pin_level = level_reg;
endmodule

// file: core/boost_select.sv
// picks the boost byte applied to the primary serial input
`timescale 1ns/1ps
`include "reclocker_consts.svh"
module boost_select
  import reclocker_pkg::*;
(
  // configuration in, selection out
  boost_sel_if.sel bus
);
  // manual replacement wins over every rate path
  wire manual_replace = bus.boost_pin_override & bus.manual_boost_override;
  wire pin_bypass = ~bus.boost_pin_override & bus.pin_bypass;
  wire low_rate = (bus.data_rate == RATE_SD) || (bus.data_rate == RATE_HD);
  wire fixed_path = low_rate || (bus.data_rate == RATE_3G && !bus.mid_rate_adapt_enable);
  // override hands the decision to the mode field; 00 manual, 01 automatic
  wire mode_auto = bus.adaptation_override ? (bus.adapt_mode == `ADAPT_MODE_AUTO) : 1'b1;

  assign bus.adapt_on = !manual_replace && !pin_bypass && !fixed_path && mode_auto;
  assign bus.boost = manual_replace ? bus.manual_boost_byte :
                     pin_bypass ? 8'h00 :
                     fixed_path ? bus.low_rate_boost :
                     mode_auto ? bus.table_boost : bus.manual_boost_byte;
  assign bus.source = manual_replace ? SRC_MANUAL :
                      pin_bypass ? SRC_BYPASS :
                      fixed_path ? SRC_FIXED :
                      mode_auto ? SRC_TABLE : SRC_MANUAL;
endmodule

// file: core/reclocker_override_eq_regs.sv
// override, low-rate boost, eye monitor enable and boost table registers with their steering
//
// Overview of operation
// - fixed low-rate boost byte drives primary input equalizer at 270M and 1.5G.
// - with mid-rate adaptation disabled, the fixed boost also serves the 3G rate.
// - override bit 0 disables 3G equalizer adaptation when 0, enables it when 1.
// - every boost byte holds four 2-bit stage controls, stage 0 in the top bits.
// - eye monitor enable, default on, checks eye opening each interval after lock.
// - override bit 5 hands adaptation choice from automatic to the mode field.
// - override bit 4 takes input routing from the route field instead of strap.
// - override bit 3 takes output mux from the mux field instead of strap.
// - override bit 2 takes rate family from the rate field instead of strap.
// - override bit 1 moves boost bypass from strap to manual override controls.
// - four table entries at consecutive offsets, defaults 00, 40, 80 and 50.
// - mode field 00 selects manual equalization, 01 automatic adaptation.
// - route field 10 feeds second output only, 11 both; others invalid.
// - rate field 00 selects video rates, 01 ethernet rate; others invalid.
// - with override bit 1 set, manual override bit replaces internal boost with the manual boost byte.
`timescale 1ns/1ps
`include "reclocker_consts.svh"
module reclocker_override_eq_regs
  import reclocker_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register access port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // strap pins
  input wire logic in_out_sel_pin,
  input wire logic out_ctrl_pin,
  // fields held in neighbouring register slices
  input wire logic [1:0] adapt_mode_field,
  input wire logic [1:0] input_route_field,
  input wire logic [1:0] output_mux_field,
  input wire logic [1:0] rate_select_field,
  input wire logic manual_boost_override,
  input wire logic [7:0] manual_boost_byte,
  // datapath status
  input wire data_rate_t data_rate,
  input wire logic [1:0] adapt_index,
  input wire logic lock_adapt_done,
  input wire logic eye_interval_tick,
  // equalizer steering
  output logic [7:0] eq_boost,
  output boost_src_t eq_boost_source,
  output logic eq_bypass,
  output logic adapt_enable,
  // routing and rate steering
  output logic [1:0] input_route,
  output logic input_route_valid,
  output logic [1:0] output_mux,
  output logic [1:0] rate_family,
  output logic rate_family_valid,
  // eye monitor
  output logic eye_check_start,
  output logic eye_monitor_armed
);
  logic [7:0] low_rate_boost_reg;
  logic [7:0] reserved_ctrl_d_reg;
  logic [7:0] eye_lock_monitor_enable_reg;
  logic [7:0] pin_override_control_reg;
  logic [7:0] adapt_boost_entry_reg [4];
  logic [7:0] rdata_reg;
  logic rd_valid_reg;
  logic [7:0] eq_boost_reg;
  boost_src_t eq_boost_source_reg;
  logic eq_bypass_reg;
  logic adapt_enable_reg;
  logic [1:0] input_route_reg;
  logic input_route_valid_reg;
  logic [1:0] output_mux_reg;
  logic [1:0] rate_family_reg;
  logic rate_family_valid_reg;
  eye_state_t eye_state_reg;
  eye_state_t eye_state_next;
  logic eye_check_reg;
  logic [1:0] strap_level;

  // register decode
  wire sel_low_rate = reg_addr == `OFS_LOW_RATE_BOOST;
  wire sel_rsvd_a = reg_addr == `OFS_RESERVED_STATUS_A;
  wire sel_rsvd_b = reg_addr == `OFS_RESERVED_STATUS_B;
  wire sel_rsvd_c = reg_addr == `OFS_RESERVED_STATUS_C;
  wire sel_rsvd_d = reg_addr == `OFS_RESERVED_CTRL_D;
  wire sel_eye_en = reg_addr == `OFS_EYE_LOCK_MONITOR_ENABLE;
  wire sel_override = reg_addr == `OFS_PIN_OVERRIDE_CONTROL;
  wire sel_table = reg_addr >= `OFS_ADAPT_BOOST_ENTRY_0 && reg_addr <= `OFS_ADAPT_BOOST_ENTRY_3;
  wire [1:0] table_slot = reg_addr[1:0];

  // override control fields and eye monitor enable
  wire mid_rate_adapt_enable = pin_override_control_reg[`BIT_MID_RATE_ADAPT_ENABLE];
  wire boost_pin_override = pin_override_control_reg[`BIT_BOOST_PIN_OVERRIDE];
  wire rate_family_override = pin_override_control_reg[`BIT_RATE_FAMILY_OVERRIDE];
  wire output_mux_override = pin_override_control_reg[`BIT_OUTPUT_MUX_OVERRIDE];
  wire input_route_override = pin_override_control_reg[`BIT_INPUT_ROUTE_OVERRIDE];
  wire adaptation_override = pin_override_control_reg[`BIT_ADAPTATION_OVERRIDE];
  wire eye_monitor_en = eye_lock_monitor_enable_reg[`BIT_EYE_MONITOR_EN];

  // filtered straps: bit 0 input/output select, bit 1 output control
  wire strap_in_out_sel = strap_level[0];
  wire strap_out_ctrl = strap_level[1];

  // read mux, reserved status words read back their fixed values
  wire [7:0] read_word = sel_low_rate ? low_rate_boost_reg :
                         sel_rsvd_a ? `RST_RESERVED_STATUS_A :
                         sel_rsvd_b ? `RST_RESERVED_STATUS_B :
                         sel_rsvd_c ? `RST_RESERVED_STATUS_C :
                         sel_rsvd_d ? reserved_ctrl_d_reg :
                         sel_eye_en ? eye_lock_monitor_enable_reg :
                         sel_override ? pin_override_control_reg :
                         sel_table ? adapt_boost_entry_reg[table_slot] : 8'h00;

  // strap side: route and rate come from the same select pin
  wire [1:0] strap_route = strap_in_out_sel ? `ROUTE_SECOND_ONLY : `ROUTE_BOTH;
  wire [1:0] strap_rate = strap_in_out_sel ? `RATE_FAMILY_ETHERNET : `RATE_FAMILY_VIDEO;
  wire [1:0] strap_mux = {1'b0, strap_out_ctrl};
  wire [1:0] route_next = input_route_override ? input_route_field : strap_route;
  wire [1:0] mux_next = output_mux_override ? output_mux_field : strap_mux;
  wire [1:0] rate_next = rate_family_override ? rate_select_field : strap_rate;
  // only two route codes and two rate codes mean anything
  wire route_ok = route_next == `ROUTE_SECOND_ONLY || route_next == `ROUTE_BOTH;
  wire rate_ok = rate_next == `RATE_FAMILY_VIDEO || rate_next == `RATE_FAMILY_ETHERNET;

  boost_sel_if sel_bus ();

  assign sel_bus.low_rate_boost = low_rate_boost_reg;
  assign sel_bus.table_boost = adapt_boost_entry_reg[adapt_index];
  assign sel_bus.manual_boost_byte = manual_boost_byte;
  assign sel_bus.manual_boost_override = manual_boost_override;
  assign sel_bus.boost_pin_override = boost_pin_override;
  assign sel_bus.pin_bypass = strap_out_ctrl;
  assign sel_bus.mid_rate_adapt_enable = mid_rate_adapt_enable;
  assign sel_bus.adaptation_override = adaptation_override;
  assign sel_bus.adapt_mode = adapt_mode_field;
  assign sel_bus.data_rate = data_rate;

  strap_sync u_strap_sync (
    .clk(clk),
    .rstn(rstn),
    .pin_in({out_ctrl_pin, in_out_sel_pin}),
    .pin_level(strap_level)
  );

  boost_select u_boost_select (
    .bus(sel_bus.sel)
  );

  // writable registers; reserved status words ignore writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_rate_boost_reg <= `RST_LOW_RATE_BOOST;
      reserved_ctrl_d_reg <= `RST_RESERVED_CTRL_D;
      eye_lock_monitor_enable_reg <= `RST_EYE_LOCK_MONITOR_ENABLE;
      pin_override_control_reg <= `RST_PIN_OVERRIDE_CONTROL;
    end else if (reg_wr_en) begin
      if (sel_low_rate)
        low_rate_boost_reg <= reg_wdata;
      if (sel_rsvd_d)
        reserved_ctrl_d_reg <= reg_wdata;
      if (sel_eye_en)
        eye_lock_monitor_enable_reg <= reg_wdata;
      if (sel_override)
        pin_override_control_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adapt_boost_entry_reg[0] <= `RST_ADAPT_BOOST_ENTRY_0;
      adapt_boost_entry_reg[1] <= `RST_ADAPT_BOOST_ENTRY_1;
      adapt_boost_entry_reg[2] <= `RST_ADAPT_BOOST_ENTRY_2;
      adapt_boost_entry_reg[3] <= `RST_ADAPT_BOOST_ENTRY_3;
    end else if (reg_wr_en && sel_table) begin
      adapt_boost_entry_reg[table_slot] <= reg_wdata;
    end
  end

  // read data lands one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd_en ? read_word : rdata_reg;
      rd_valid_reg <= reg_rd_en;
    end
  end

  // steering outputs registered so the analog side never sees decode glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eq_boost_reg <= 8'h00;
      eq_boost_source_reg <= SRC_FIXED;
      eq_bypass_reg <= 1'b0;
      adapt_enable_reg <= 1'b0;
    end else begin
      eq_boost_reg <= sel_bus.boost;
      eq_boost_source_reg <= sel_bus.source;
      eq_bypass_reg <= sel_bus.source == SRC_BYPASS;
      adapt_enable_reg <= sel_bus.adapt_on;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      input_route_reg <= `ROUTE_BOTH;
      input_route_valid_reg <= 1'b1;
      output_mux_reg <= 2'h0;
      rate_family_reg <= `RATE_FAMILY_VIDEO;
      rate_family_valid_reg <= 1'b1;
    end else begin
      input_route_reg <= route_next;
      input_route_valid_reg <= route_ok;
      output_mux_reg <= mux_next;
      rate_family_reg <= rate_next;
      rate_family_valid_reg <= rate_ok;
    end
  end

  // eye monitor: arms after lock and adaptation finish, fires on each interval tick
  always_comb begin
    eye_state_next = eye_state_reg;
    case (eye_state_reg)
      EYE_OFF: begin
        if (eye_monitor_en)
          eye_state_next = EYE_WAIT;
      end
      EYE_WAIT: begin
        if (!eye_monitor_en)
          eye_state_next = EYE_OFF;
        else if (lock_adapt_done)
          eye_state_next = EYE_RUN;
      end
      EYE_RUN: begin
        if (!eye_monitor_en)
          eye_state_next = EYE_OFF;
        else if (!lock_adapt_done)
          eye_state_next = EYE_WAIT;
      end
      default: eye_state_next = EYE_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eye_state_reg <= EYE_OFF;
      eye_check_reg <= 1'b0;
    end else begin
      eye_state_reg <= eye_state_next;
      // a tick in the cycle lock is lost is dropped, the eye is not trustworthy
      eye_check_reg <= eye_state_reg == EYE_RUN && eye_monitor_en && lock_adapt_done && eye_interval_tick;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign eq_boost = eq_boost_reg;
  assign eq_boost_source = eq_boost_source_reg;
  assign eq_bypass = eq_bypass_reg;
  assign adapt_enable = adapt_enable_reg;
  assign input_route = input_route_reg;
  assign input_route_valid = input_route_valid_reg;
  assign output_mux = output_mux_reg;
  assign rate_family = rate_family_reg;
  assign rate_family_valid = rate_family_valid_reg;
  assign eye_check_start = eye_check_reg;
  assign eye_monitor_armed = eye_state_reg == EYE_RUN;

  // low rates use the fixed byte unless a manual replacement or pin bypass is in force
  property p_low_rate_fixed;
    @(posedge clk) disable iff (!rstn)
      (data_rate == RATE_SD || data_rate == RATE_HD) && !boost_pin_override && !strap_out_ctrl
        |=> eq_boost == $past(low_rate_boost_reg) && eq_boost_source == SRC_FIXED;
  endproperty
  a_low_rate_fixed: assert property (p_low_rate_fixed) else $error("low rate boost not fixed byte");

  property p_mid_rate_fixed;
    @(posedge clk) disable iff (!rstn)
      data_rate == RATE_3G && !mid_rate_adapt_enable && !boost_pin_override && !strap_out_ctrl
        |=> eq_boost == $past(low_rate_boost_reg) && !adapt_enable;
  endproperty
  a_mid_rate_fixed: assert property (p_mid_rate_fixed) else $error("3G without adaptation not fixed");

  property p_mid_rate_adapt;
    @(posedge clk) disable iff (!rstn)
      data_rate == RATE_3G && mid_rate_adapt_enable && !adaptation_override && !boost_pin_override
        && !strap_out_ctrl |=> adapt_enable;
  endproperty
  a_mid_rate_adapt: assert property (p_mid_rate_adapt) else $error("3G adaptation not enabled");

  property p_table_stage;
    @(posedge clk) disable iff (!rstn)
      sel_bus.source == SRC_TABLE && adapt_index == 2'h1
        |=> stage_of(eq_boost, 2'h0) == $past(adapt_boost_entry_reg[1][7:6])
          && stage_of(eq_boost, 2'h3) == $past(adapt_boost_entry_reg[1][1:0]);
  endproperty
  a_table_stage: assert property (p_table_stage) else $error("stage fields misplaced");

  property p_eye_needs_enable;
    @(posedge clk) disable iff (!rstn)
      eye_check_start |-> $past(eye_monitor_en) && $past(lock_adapt_done) && $past(eye_interval_tick);
  endproperty
  a_eye_needs_enable: assert property (p_eye_needs_enable) else $error("eye check without cause");

  property p_eye_fires;
    @(posedge clk) disable iff (!rstn)
      eye_state_reg == EYE_RUN && eye_monitor_en && lock_adapt_done && eye_interval_tick ##1 1'b1
        |-> eye_check_start;
  endproperty
  a_eye_fires: assert property (p_eye_fires) else $error("eye check missed a tick");

  property p_mode_manual;
    @(posedge clk) disable iff (!rstn)
      adaptation_override && adapt_mode_field == `ADAPT_MODE_MANUAL |=> !adapt_enable;
  endproperty
  a_mode_manual: assert property (p_mode_manual) else $error("manual mode still adapting");

  property p_route_override;
    @(posedge clk) disable iff (!rstn)
      input_route_override |=> input_route == $past(input_route_field)
        && input_route_valid == ($past(input_route_field) >= `ROUTE_SECOND_ONLY);
  endproperty
  a_route_override: assert property (p_route_override) else $error("route field not applied");

  property p_mux_override;
    @(posedge clk) disable iff (!rstn)
      output_mux_override |=> output_mux == $past(output_mux_field);
  endproperty
  a_mux_override: assert property (p_mux_override) else $error("output mux field not applied");

  property p_rate_override;
    @(posedge clk) disable iff (!rstn)
      rate_family_override |=> rate_family == $past(rate_select_field)
        && rate_family_valid == ($past(rate_select_field) <= `RATE_FAMILY_ETHERNET);
  endproperty
  a_rate_override: assert property (p_rate_override) else $error("rate field not applied");

  property p_manual_replace;
    @(posedge clk) disable iff (!rstn)
      boost_pin_override && manual_boost_override |=> eq_boost == $past(manual_boost_byte) && !eq_bypass;
  endproperty
  a_manual_replace: assert property (p_manual_replace) else $error("manual boost not applied");

  property p_table_readback;
    @(posedge clk) disable iff (!rstn)
      reg_wr_en && reg_addr == `OFS_ADAPT_BOOST_ENTRY_1 ##1 reg_rd_en && reg_addr == `OFS_ADAPT_BOOST_ENTRY_1 && !reg_wr_en
        |=> reg_rdata == $past(reg_wdata, 2) && reg_rd_valid;
  endproperty
  a_table_readback: assert property (p_table_readback) else $error("table entry read back wrong");
endmodule

// file: test/host_model.sv
// management host model driving the byte register port
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    // released lines show the inverse so a stale value cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // valid stands exactly one cycle after the read is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = reg_rd_valid;
    d = reg_rdata;
  endtask
  // write, then read the same place on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    reg_wdata <= ~d;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = reg_rd_valid;
    q = reg_rdata;
  endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the override and boost register slice
`timescale 1ns/1ps
module testbench;
  import reclocker_pkg::*;
  logic clk, rstn, iosp, ocp, mbo, done, tick;
  logic [1:0] amf, irf, omf, rsf, aidx;
  logic [7:0] mbb;
  data_rate_t rate;
  logic wr_en, rd_en, rd_valid, eq_bypass, adapt_enable, route_valid, rate_valid, eye_start, eye_armed;
  logic [7:0] addr, wdata, rdata, eq_boost;
  logic [1:0] route, out_mux, rate_fam;
  boost_src_t src;
  int num_errors = 0;
  int n_compared = 0;
  localparam logic [7:0] rst_tab [0:10] = '{8'h00, 8'h00, 8'h96, 8'h90, 8'h00, 8'h80, 8'h01, 8'h00, 8'h40, 8'h80, 8'h50};

  host_model host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rd_valid(rd_valid));
  reclocker_override_eq_regs dut (.clk(clk), .rstn(rstn), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid), .in_out_sel_pin(iosp),
    .out_ctrl_pin(ocp), .adapt_mode_field(amf), .input_route_field(irf), .output_mux_field(omf),
    .rate_select_field(rsf), .manual_boost_override(mbo), .manual_boost_byte(mbb), .data_rate(rate),
    .adapt_index(aidx), .lock_adapt_done(done), .eye_interval_tick(tick), .eq_boost(eq_boost),
    .eq_boost_source(src), .eq_bypass(eq_bypass), .adapt_enable(adapt_enable), .input_route(route),
    .input_route_valid(route_valid), .output_mux(out_mux), .rate_family(rate_fam),
    .rate_family_valid(rate_valid), .eye_check_start(eye_start), .eye_monitor_armed(eye_armed));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk("rd_valid", ok, 10'h001);
    chk("rdata", d, e);
  endtask

  // fixed boost outranks adaptation; manual replace and strap bypass outrank both
  function automatic logic [9:0] exp_sel(input logic [7:0] ov, input logic [7:0] lrb, input logic [7:0] tab);
    if (ov[1] && mbo) return {SRC_MANUAL, mbb};
    if (!ov[1] && ocp) return {SRC_BYPASS, 8'h00};
    if (rate == RATE_SD || rate == RATE_HD || (rate == RATE_3G && !ov[0])) return {SRC_FIXED, lrb};
    if (!ov[5] || amf == 2'h1) return {SRC_TABLE, tab};
    return {SRC_MANUAL, mbb};
  endfunction

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    logic [7:0] ov, lrb, tab, v [0:10];
    logic [9:0] e;
    logic [12:0] r;
    logic [7:0] q;
    logic ok;
    {rstn, iosp, ocp, mbo, done, tick, amf, irf, omf, rsf, aidx, mbb} = '0;
    rate = RATE_SD;
    void'($urandom(32'hda05b440));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++) rchk(8'h39 + 8'(i), rst_tab[i]);
    rchk(8'h38, 8'h00);
    rchk(8'h44, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 11; i++) begin
      v[i] = 8'($urandom());
      if (i == 6) v[i][7:6] = 2'h0;
      host.wr(8'h39 + 8'(i), v[i]);
    end
    // read-only reserved places keep their reset value
    for (int i = 0; i < 11; i++) rchk(8'h39 + 8'(i), (i == 0 || i == 2 || i == 3) ? rst_tab[i] : v[i]);
    tab = 8'($urandom());
    host.wr_rd(8'h41, tab, q, ok);
    chk("wr_rd_valid", ok, 10'h001);
    chk("wr_rd_data", q, tab);
    $display("register access done");
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      rate <= data_rate_t'($urandom_range(3));
      r = 13'($urandom());
      {iosp, ocp, mbo, amf, irf, omf, rsf, aidx} <= r;
      mbb <= 8'($urandom());
      lrb = 8'($urandom());
      tab = 8'($urandom());
      ov = {2'h0, 6'($urandom())};
      host.wr(8'h3a, lrb);
      host.wr(8'h40 + 8'(r[1:0]), tab);
      host.wr(8'h3f, ov);
      repeat (6) @(posedge clk);
      #1;
      e = exp_sel(ov, lrb, tab);
      chk("eq_boost", eq_boost, e[7:0]);
      chk("source", src, e[9:8]);
      chk("bypass", eq_bypass, e[9:8] == SRC_BYPASS);
      chk("adapt", adapt_enable, e[9:8] == SRC_TABLE);
      e[1:0] = ov[4] ? irf : (iosp ? 2'h2 : 2'h3);
      chk("route", route, e[1:0]);
      chk("route_valid", route_valid, e[1]);
      chk("out_mux", out_mux, ov[3] ? omf : {1'b0, ocp});
      e[1:0] = ov[2] ? rsf : {1'b0, iosp};
      chk("rate", rate_fam, e[1:0]);
      chk("rate_valid", rate_valid, !e[1]);
    end
    $display("steering done");
    for (int k = 0; k < 2; k++) begin
      host.wr(8'h3e, k == 0 ? 8'h80 : 8'h00);
      @(posedge clk);
      done <= 1'b1;
      repeat (3) @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      #1;
      chk("eye_start", eye_start, k == 0);
      chk("eye_armed", eye_armed, k == 0);
      @(posedge clk);
      #1;
      chk("eye_start_end", eye_start, 10'h000);
    end
    $display("eye monitor done");
    stop_test();
  end
endmodule
